//--- rtl/ssdp_map.vh
// Purpose: Constants for the pin-level command, address and write data front end.
// Assumes: Core clock at 50 MHz; all pins are asynchronous to it.
// Notes: Included by the front end, its checker, the controller model and the bench.
// Operation
// - Capture the 23-bit address on main clock rising edge for row/column select.
// - On mode register set, store the captured address as the new configuration.
// - Use the 3-bit group select to pick the internal group for each command.
// - Sample write and auto-renew inputs each main clock rise, decode with select.
// - Decoder works while chip select is low; high select ignores new commands.
// - Raising chip select never aborts bursts or renews already running.
// - Sample the 18-bit write data on both edges of the write clock pair.
// - Sample write mask on both write clock edges; masked beats are not stored.
// - Main clock pair is one differential pair; latch only on true-clock rise.
// - Drive read data on both read clock edges; bits 0-8 pair 0, 9-17 pair 1.
// - Assert read valid flag edge-aligned with the read clock pair.
`ifndef SSDP_MAP_VH
`define SSDP_MAP_VH

`define SSDP_ADDR_W      23
`define SSDP_GRP_W       3
`define SSDP_DATA_W      18
`define SSDP_BEAT_W      3
`define SSDP_WBUF_W      47
`define SSDP_WBUF_DEPTH  16
`define SSDP_WBUF_AW     4

`define SSDP_CMD_MRS     2'h0
`define SSDP_CMD_WRITE   2'h1
`define SSDP_CMD_RENEW   2'h2
`define SSDP_CMD_READ    2'h3

`define SSDP_MODE_RST    23'h000000
`define SSDP_MODE_BL_LSB 3
`define SSDP_MODE_BL_MSB 4

`define SSDP_CLK_NS      20
`define SSDP_RENEW_NS    200
`define SSDP_RENEW_CYC   ((`SSDP_RENEW_NS + `SSDP_CLK_NS - 1) / `SSDP_CLK_NS)
`define SSDP_RCLK_HALF_NS 40
`define SSDP_RCLK_HALF   (`SSDP_RCLK_HALF_NS / `SSDP_CLK_NS)

`endif

//--- rtl/ssdp_wbuf.v
// Purpose: Write beat buffer between pin capture and the array side.
// Assumes: Single clock; drain side may stall at will.
// Notes: Read data come from a register stage in front of the store.
`timescale 1ns/1ps
module ssdp_wbuf #(
  parameter WIDTH = 47,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  // Clock and reset
  input  wire             i_core_clk,
  input  wire             i_rst_b,
  // Fill side
  input  wire             i_in_valid,
  output wire             o_in_ready,
  input  wire [WIDTH-1:0] i_in_data,
  // Drain side
  output reg              o_out_valid,
  input  wire             i_out_ready,
  output reg  [WIDTH-1:0] o_out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_reg;
  reg [AW-1:0]    rd_ptr_reg;
  reg [AW:0]      count_reg;
  wire            full  = (count_reg == DEPTH[AW:0]);
  wire            empty = (count_reg == {(AW+1){1'b0}});
  wire            push  = i_in_valid & ~full;
  wire            pop   = ~empty & (~o_out_valid | i_out_ready);

  assign o_in_ready = ~full;

  always @(posedge i_core_clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= i_in_data;
    end
  end

  always @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wr_ptr_reg  <= {AW{1'b0}};
      rd_ptr_reg  <= {AW{1'b0}};
      count_reg   <= {(AW+1){1'b0}};
      o_out_valid <= 1'b0;
      o_out_data  <= {WIDTH{1'b0}};
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
        o_out_data <= mem[rd_ptr_reg];
      end
      if (push & ~pop) begin
        count_reg <= count_reg + {{AW{1'b0}}, 1'b1};
      end else if (pop & ~push) begin
        count_reg <= count_reg - {{AW{1'b0}}, 1'b1};
      end
      if (pop) begin
        o_out_valid <= 1'b1;
      end else if (i_out_ready) begin
        o_out_valid <= 1'b0;
      end
    end
  end
endmodule // ssdp_wbuf

//--- rtl/ssdp_pin_if.v
// Purpose: Device-side capture of commands, addresses and write data from the pins.
// Assumes: Pin clocks are far slower than the 50 MHz core clock.
// Notes: Every pin passes two flip-flops, so clock and data keep their alignment.
`timescale 1ns/1ps
`include "ssdp_map.vh"
module ssdp_pin_if (
  // Core clock and reset
  input  wire                    i_core_clk,
  input  wire                    i_rst_b,
  // Main clock pair and command pins
  input  wire                    i_main_clk_pair_p,
  input  wire                    i_main_clk_pair_n,
  input  wire                    i_cs_b,
  input  wire                    i_we_b,
  input  wire                    i_renew_b,
  input  wire [`SSDP_ADDR_W-1:0] i_addr,
  input  wire [`SSDP_GRP_W-1:0]  i_grp,
  // Write clock pair, data and mask pins
  input  wire                    i_write_clk_pair_p,
  input  wire                    i_write_clk_pair_n,
  input  wire [`SSDP_DATA_W-1:0] i_wdata,
  input  wire                    i_write_mask,
  // Decoded command to the array side
  output reg                     o_cmd_valid,
  output reg  [1:0]              o_cmd_kind,
  output reg  [`SSDP_GRP_W-1:0]  o_cmd_grp,
  output reg  [`SSDP_ADDR_W-1:0] o_cmd_addr,
  output reg  [`SSDP_ADDR_W-1:0] o_mode_cfg,
  output reg                     o_renew_busy,
  output reg                     o_write_busy,
  // Write beats to the array side
  output wire                    o_beat_valid,
  input  wire                    i_beat_ready,
  output wire [`SSDP_DATA_W-1:0] o_beat_data,
  output wire [`SSDP_GRP_W-1:0]  o_beat_grp,
  output wire [`SSDP_ADDR_W-1:0] o_beat_addr,
  output wire [`SSDP_BEAT_W-1:0] o_beat_idx,
  output wire                    o_wbuf_ready,
  output reg                     o_beat_drop,
  // Read data from the array side
  input  wire                    i_rd_valid,
  output wire                    o_rd_ready,
  input  wire [`SSDP_DATA_W-1:0] i_rd_data,
  // Read pins
  output reg  [1:0]              o_read_clk_pair_p,
  output reg  [1:0]              o_read_clk_pair_n,
  output reg  [`SSDP_DATA_W-1:0] o_read_data,
  output reg                     o_read_valid_flag
);
  localparam ST_IDLE  = 2'b01;
  localparam ST_BURST = 2'b10;
  localparam CSYNC_W  = 5 + `SSDP_ADDR_W + `SSDP_GRP_W;
  localparam WSYNC_W  = 3 + `SSDP_DATA_W;
  localparam [31:0] RENEW_FULL = `SSDP_RENEW_CYC;

  // Beats per write burst from the two-bit length field.
  function [`SSDP_BEAT_W:0] burst_beats;
    input [1:0] code;
    begin
      case (code)
        2'h0:    burst_beats = 4'h2;
        2'h1:    burst_beats = 4'h4;
        2'h2:    burst_beats = 4'h8;
        default: burst_beats = 4'h8;
      endcase
    end
  endfunction

  // Pair qualified edge: the true line moved and the complement stands opposite.
  function pair_edge;
    input now_p;
    input old_p;
    input now_n;
    input want_high;
    begin
      pair_edge = (now_p != old_p) && (now_p == want_high) && (now_n == ~now_p);
    end
  endfunction

  reg  [CSYNC_W-1:0] csync1_reg;
  reg  [CSYNC_W-1:0] csync2_reg;
  reg                mclk_old_reg;
  reg  [WSYNC_W-1:0] wsync1_reg;
  reg  [WSYNC_W-1:0] wsync2_reg;
  reg                wclk_old_reg;

  always @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      csync1_reg   <= {CSYNC_W{1'b0}};
      csync2_reg   <= {CSYNC_W{1'b0}};
      mclk_old_reg <= 1'b0;
      wsync1_reg   <= {WSYNC_W{1'b0}};
      wsync2_reg   <= {WSYNC_W{1'b0}};
      wclk_old_reg <= 1'b0;
    end else begin
      csync1_reg   <= {i_main_clk_pair_p, i_main_clk_pair_n, i_cs_b, i_we_b,
                       i_renew_b, i_addr, i_grp};
      csync2_reg   <= csync1_reg;
      mclk_old_reg <= csync2_reg[CSYNC_W-1];
      wsync1_reg   <= {i_write_clk_pair_p, i_write_clk_pair_n, i_write_mask, i_wdata};
      wsync2_reg   <= wsync1_reg;
      wclk_old_reg <= wsync2_reg[WSYNC_W-1];
    end
  end

  wire                    m_p    = csync2_reg[CSYNC_W-1];
  wire                    m_n    = csync2_reg[CSYNC_W-2];
  wire                    s_cs_b = csync2_reg[CSYNC_W-3];
  wire [1:0]              s_cmd  = csync2_reg[CSYNC_W-4:CSYNC_W-5];
  wire [`SSDP_ADDR_W-1:0] s_addr = csync2_reg[`SSDP_ADDR_W+`SSDP_GRP_W-1:`SSDP_GRP_W];
  wire [`SSDP_GRP_W-1:0]  s_grp  = csync2_reg[`SSDP_GRP_W-1:0];
  wire                    w_p    = wsync2_reg[WSYNC_W-1];
  wire                    w_n    = wsync2_reg[WSYNC_W-2];
  wire                    s_mask = wsync2_reg[`SSDP_DATA_W];
  wire [`SSDP_DATA_W-1:0] s_wd   = wsync2_reg[`SSDP_DATA_W-1:0];

  // Only the true clock rise latches; the complement merely qualifies it.
  wire mclk_rise = pair_edge(m_p, mclk_old_reg, m_n, 1'b1);
  wire cmd_take  = mclk_rise & ~s_cs_b;
  wire wclk_edge = pair_edge(w_p, wclk_old_reg, w_n, 1'b1) |
                   pair_edge(w_p, wclk_old_reg, w_n, 1'b0);

  reg  [1:0]              wst_reg;
  reg  [1:0]              wst_next;
  reg  [`SSDP_BEAT_W:0]   left_reg;
  reg  [`SSDP_BEAT_W:0]   left_next;
  reg  [`SSDP_BEAT_W-1:0] idx_reg;
  reg  [`SSDP_BEAT_W-1:0] idx_next;
  reg  [`SSDP_ADDR_W-1:0] waddr_reg;
  reg  [`SSDP_GRP_W-1:0]  wgrp_reg;
  reg  [7:0]              renew_cnt_reg;
  wire                    in_ready;
  wire                    wr_cmd   = cmd_take && (s_cmd == `SSDP_CMD_WRITE);
  wire                    beat_in  = (wst_reg == ST_BURST) && wclk_edge;
  // The mask sampled on this edge judges this edge's word alone.
  wire                    beat_keep = beat_in & ~s_mask;

  // A new write restarts the burst; raising select has no effect on it.
  always @* begin
    wst_next  = wst_reg;
    left_next = left_reg;
    idx_next  = idx_reg;
    case (wst_reg)
      ST_IDLE: begin
        if (wr_cmd) begin
          wst_next  = ST_BURST;
          left_next = burst_beats(o_mode_cfg[`SSDP_MODE_BL_MSB:`SSDP_MODE_BL_LSB]);
          idx_next  = {`SSDP_BEAT_W{1'b0}};
        end
      end
      ST_BURST: begin
        if (beat_in) begin
          left_next = left_reg - {{`SSDP_BEAT_W{1'b0}}, 1'b1};
          idx_next  = idx_reg + {{(`SSDP_BEAT_W-1){1'b0}}, 1'b1};
          if (left_reg == {{`SSDP_BEAT_W{1'b0}}, 1'b1}) begin
            wst_next = ST_IDLE;
          end
        end
        if (wr_cmd) begin
          left_next = burst_beats(o_mode_cfg[`SSDP_MODE_BL_MSB:`SSDP_MODE_BL_LSB]);
          idx_next  = {`SSDP_BEAT_W{1'b0}};
          wst_next  = ST_BURST;
        end
      end
      default: begin
        wst_next  = ST_IDLE;
        left_next = {(`SSDP_BEAT_W+1){1'b0}};
        idx_next  = {`SSDP_BEAT_W{1'b0}};
      end
    endcase
  end

  always @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wst_reg       <= ST_IDLE;
      left_reg      <= {(`SSDP_BEAT_W+1){1'b0}};
      idx_reg       <= {`SSDP_BEAT_W{1'b0}};
      waddr_reg     <= {`SSDP_ADDR_W{1'b0}};
      wgrp_reg      <= {`SSDP_GRP_W{1'b0}};
      o_cmd_valid   <= 1'b0;
      o_cmd_kind    <= `SSDP_CMD_READ;
      o_cmd_grp     <= {`SSDP_GRP_W{1'b0}};
      o_cmd_addr    <= {`SSDP_ADDR_W{1'b0}};
      o_mode_cfg    <= `SSDP_MODE_RST;
      renew_cnt_reg <= 8'h00;
      o_renew_busy  <= 1'b0;
      o_write_busy  <= 1'b0;
      o_beat_drop   <= 1'b0;
    end else begin
      wst_reg      <= wst_next;
      left_reg     <= left_next;
      idx_reg      <= idx_next;
      o_write_busy <= (wst_next == ST_BURST);
      o_cmd_valid  <= cmd_take;
      o_beat_drop  <= beat_keep & ~in_ready;
      if (cmd_take) begin
        o_cmd_kind <= s_cmd;
        o_cmd_grp  <= s_grp;
        o_cmd_addr <= s_addr;
      end
      if (wr_cmd) begin
        waddr_reg <= s_addr;
        wgrp_reg  <= s_grp;
      end
      if (cmd_take && (s_cmd == `SSDP_CMD_MRS)) begin
        o_mode_cfg <= s_addr;
      end
      // The renew runs out its time even if select goes high meanwhile.
      if (cmd_take && (s_cmd == `SSDP_CMD_RENEW)) begin
        renew_cnt_reg <= RENEW_FULL[7:0];
        o_renew_busy  <= 1'b1;
      end else if (renew_cnt_reg != 8'h00) begin
        renew_cnt_reg <= renew_cnt_reg - 8'h01;
        o_renew_busy  <= (renew_cnt_reg != 8'h01);
      end
    end
  end

  // The pins cannot be stalled, so a beat arriving at a full buffer is lost.
  ssdp_wbuf #(
    .WIDTH (`SSDP_WBUF_W),
    .DEPTH (`SSDP_WBUF_DEPTH),
    .AW    (`SSDP_WBUF_AW)
  ) u_wbuf (
    .i_core_clk  (i_core_clk),
    .i_rst_b     (i_rst_b),
    .i_in_valid  (beat_keep),
    .o_in_ready  (in_ready),
    .i_in_data   ({s_wd, wgrp_reg, waddr_reg, idx_reg}),
    .o_out_valid (o_beat_valid),
    .i_out_ready (i_beat_ready),
    .o_out_data  ({o_beat_data, o_beat_grp, o_beat_addr, o_beat_idx})
  );

  assign o_wbuf_ready = in_ready;

  // Read side: a free-running clock pair from a divider, data moved on each edge.
  reg  [7:0] rdiv_reg;
  wire       rtoggle = (rdiv_reg == (`SSDP_RCLK_HALF - 1));

  assign o_rd_ready = rtoggle;

  always @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rdiv_reg          <= 8'h00;
      o_read_clk_pair_p <= 2'b00;
      o_read_clk_pair_n <= 2'b11;
      o_read_data       <= {`SSDP_DATA_W{1'b0}};
      o_read_valid_flag <= 1'b0;
    end else begin
      rdiv_reg <= rtoggle ? 8'h00 : rdiv_reg + 8'h01;
      if (rtoggle) begin
        o_read_clk_pair_p <= ~o_read_clk_pair_p;
        o_read_clk_pair_n <= ~o_read_clk_pair_n;
        // Both halves move with both pairs, so each pair frames its own nine bits.
        o_read_data       <= i_rd_valid ? i_rd_data : {`SSDP_DATA_W{1'b0}};
        o_read_valid_flag <= i_rd_valid;
      end
    end
  end
endmodule // ssdp_pin_if

//--- sim/ssdp_pin_if_sva.sv
// Purpose: Port checker for the pin capture front end.
// Assumes: Pins hold still four core cycles around each main clock rise.
// Notes: Bound into every front end instance.
`timescale 1ns/1ps
`include "ssdp_map.vh"
module ssdp_pin_if_sva (
  // Clock, reset, pins and handshakes
  input wire                    i_core_clk, i_rst_b, i_main_clk_pair_p, i_cs_b, i_we_b,
  input wire                    i_renew_b, i_beat_ready, i_rd_valid, o_rd_ready,
  input wire [`SSDP_ADDR_W-1:0] i_addr, o_cmd_addr, o_mode_cfg,
  input wire [`SSDP_GRP_W-1:0]  i_grp, o_cmd_grp,
  // Decoded and read side outputs
  input wire                    o_cmd_valid, o_renew_busy, o_write_busy, o_beat_valid,
  input wire                    o_read_valid_flag,
  input wire [1:0]              o_cmd_kind, o_read_clk_pair_p, o_read_clk_pair_n,
  input wire [`SSDP_DATA_W-1:0] o_beat_data, i_rd_data, o_read_data
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);
  sequence s_renew_run; o_renew_busy [*8] ##1 o_renew_busy ##1 o_renew_busy; endsequence
  sequence s_rclk_half; $stable(o_read_clk_pair_p) ##1 $changed(o_read_clk_pair_p); endsequence
  chk_cmd_source: assert property (o_cmd_valid |-> $past(i_main_clk_pair_p, 3)
    && !$past(i_main_clk_pair_p, 4) && !$past(i_cs_b, 3)) else $error("stray command");
  chk_cmd_kind: assert property (o_cmd_valid |-> o_cmd_kind ==
    {$past(i_we_b, 3), $past(i_renew_b, 3)}) else $error("bad command kind");
  chk_cmd_addr: assert property (o_cmd_valid |-> o_cmd_addr == $past(i_addr, 3)
    && o_cmd_grp == $past(i_grp, 3)) else $error("bad command address");
  chk_mode_load: assert property (o_cmd_valid && o_cmd_kind == `SSDP_CMD_MRS
    |-> o_mode_cfg == o_cmd_addr) else $error("mode not loaded");
  chk_mode_hold: assert property ($changed(o_mode_cfg) |-> o_cmd_valid
    && o_cmd_kind == `SSDP_CMD_MRS) else $error("mode changed alone");
  chk_renew_time: assert property ($rose(o_renew_busy) |-> s_renew_run ##1 !o_renew_busy)
    else $error("bad renew time");
  chk_burst_arm: assert property ($rose(o_write_busy) |-> o_cmd_kind == `SSDP_CMD_WRITE)
    else $error("burst without write");
  chk_read_pair: assert property (o_read_clk_pair_n == ~o_read_clk_pair_p
    && o_read_clk_pair_p[0] == o_read_clk_pair_p[1]) else $error("read clocks apart");
  chk_read_rate: assert property ($changed(o_read_clk_pair_p) |=> s_rclk_half)
    else $error("bad read clock rate");
  chk_read_align: assert property ($changed(o_read_data) || $changed(o_read_valid_flag)
    |-> $changed(o_read_clk_pair_p)) else $error("read data off clock edge");
  chk_read_beat: assert property (o_rd_ready && i_rd_valid |=> o_read_valid_flag
    && o_read_data == $past(i_rd_data)) else $error("read beat lost");
  chk_beat_stand: assert property (o_beat_valid && !i_beat_ready |=> o_beat_valid
    && $stable(o_beat_data)) else $error("beat left early");
endmodule // ssdp_pin_if_sva
bind ssdp_pin_if ssdp_pin_if_sva u_sva (.i_core_clk, .i_rst_b, .i_main_clk_pair_p, .i_cs_b,
  .i_we_b, .i_renew_b, .i_beat_ready, .i_rd_valid, .o_rd_ready, .i_addr, .o_cmd_addr,
  .o_mode_cfg, .i_grp, .o_cmd_grp, .o_cmd_valid, .o_renew_busy, .o_write_busy, .o_beat_valid,
  .o_read_valid_flag, .o_cmd_kind, .o_read_clk_pair_p, .o_read_clk_pair_n, .o_beat_data,
  .i_rd_data, .o_read_data);

//--- sim/ssdp_ctl_model.sv
// Purpose: Memory controller as seen from the device pins.
// Assumes: Both clock pairs run free at 160 ns, the write pair 20 ns late.
// Notes: Released lines show the inverse of their last value.
`timescale 1ns/1ps
`include "ssdp_map.vh"
module ssdp_ctl_model (
  // Main clock pair and command pins
  output logic                    o_main_p, o_cs_b, o_we_b, o_renew_b,
  output wire                     o_main_n,
  output logic [`SSDP_ADDR_W-1:0] o_addr,
  output logic [`SSDP_GRP_W-1:0]  o_grp,
  // Write clock pair, data and mask
  output logic                    o_wck_p, o_wmask,
  output wire                     o_wck_n,
  output logic [`SSDP_DATA_W-1:0] o_wdata
);
  assign o_main_n = ~o_main_p;
  assign o_wck_n = ~o_wck_p;
  initial begin
    {o_main_p, o_wck_p, o_cs_b, o_we_b, o_renew_b, o_wmask} = 6'h0e;
    {o_addr, o_grp, o_wdata} = 44'h0;
    #7;
    forever #80 o_main_p = ~o_main_p;
  end
  // The write pair never stops, so the device sees it between bursts too.
  initial begin #27; forever #80 o_wck_p = ~o_wck_p; end
  task automatic cmd(input logic cs_b, we_b, renew_b, input logic [22:0] a,
                     input logic [2:0] g);
    @(negedge o_main_p);
    {o_cs_b, o_we_b, o_renew_b, o_addr, o_grp} = {cs_b, we_b, renew_b, a, g};
    @(posedge o_main_p);
  endtask
  task automatic idle();
    @(negedge o_main_p);
    o_cs_b = 1'b1;
    {o_we_b, o_renew_b, o_addr, o_grp} = ~{o_we_b, o_renew_b, o_addr, o_grp};
  endtask
  // Each beat is set before the write clock edge that takes it, since the
  // device counts the first edge after the command; later beats sit halfway.
  task automatic beat(input logic [17:0] d, input logic m);
    {o_wdata, o_wmask} = {d, m};
    @(o_wck_p);
    #40;
  endtask
endmodule // ssdp_ctl_model

//--- sim/ssdp_pin_if_bench.sv
// Purpose: Self-checking bench for the pin capture front end.
// Assumes: Pins come from the controller model; core side is driven here.
// Notes: Stimulus queues expected results; a monitor matches them.
`timescale 1ns/1ps
`include "ssdp_map.vh"
`define CHK(n, e, g) begin total_checks++; if ((e) !== (g)) begin err_total++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module ssdp_pin_if_bench;
  logic i_core_clk = 1'b0, i_rst_b = 1'b0, i_beat_ready = 1'b0, i_rd_valid = 1'b0, stall = 1'b0;
  logic [17:0] i_rd_data = 18'h0, er;
  logic [31:0] seed = 32'h42, r, rb;
  logic [46:0] eb, bq[$];
  logic [27:0] ec, cq[$];
  logic [17:0] rq[$];
  logic [1:0] last_rclk = 2'h0;
  int err_total = 0, total_checks = 0, drops = 0;
  wire i_main_clk_pair_p, i_main_clk_pair_n, i_cs_b, i_we_b, i_renew_b, i_write_clk_pair_p;
  wire i_write_clk_pair_n, i_write_mask, o_cmd_valid, o_renew_busy, o_write_busy, o_beat_valid;
  wire o_wbuf_ready, o_beat_drop, o_rd_ready, o_read_valid_flag;
  wire [1:0] o_cmd_kind, o_read_clk_pair_p, o_read_clk_pair_n;
  wire [22:0] i_addr, o_cmd_addr, o_mode_cfg, o_beat_addr;
  wire [2:0] i_grp, o_cmd_grp, o_beat_grp, o_beat_idx;
  wire [17:0] i_wdata, o_beat_data, o_read_data;
  ssdp_ctl_model u_ctl (.o_main_p(i_main_clk_pair_p), .o_main_n(i_main_clk_pair_n),
    .o_cs_b(i_cs_b), .o_we_b(i_we_b), .o_renew_b(i_renew_b), .o_addr(i_addr), .o_grp(i_grp),
    .o_wck_p(i_write_clk_pair_p), .o_wck_n(i_write_clk_pair_n), .o_wmask(i_write_mask),
    .o_wdata(i_wdata));
  ssdp_pin_if u_dut (.i_core_clk, .i_rst_b, .i_main_clk_pair_p, .i_main_clk_pair_n, .i_cs_b,
    .i_we_b, .i_renew_b, .i_addr, .i_grp, .i_write_clk_pair_p, .i_write_clk_pair_n, .i_wdata,
    .i_write_mask, .o_cmd_valid, .o_cmd_kind, .o_cmd_grp, .o_cmd_addr, .o_mode_cfg,
    .o_renew_busy, .o_write_busy, .o_beat_valid, .i_beat_ready, .o_beat_data, .o_beat_grp,
    .o_beat_addr, .o_beat_idx, .o_wbuf_ready, .o_beat_drop, .i_rd_valid, .o_rd_ready,
    .i_rd_data, .o_read_clk_pair_p, .o_read_clk_pair_n, .o_read_data, .o_read_valid_flag);
  initial forever #10 i_core_clk = ~i_core_clk;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Random drain stalls keep the buffer partly full.
  always @(posedge i_core_clk) begin
    rb = rnd();
    #2 i_beat_ready = !stall && rb[0];
  end
  // Sampled mid-cycle so every output has settled.
  always @(negedge i_core_clk) begin
    if (o_beat_valid && i_beat_ready) begin
      eb = bq.size() ? bq.pop_front() : 'x;
      `CHK("beat", eb, {o_beat_data, o_beat_grp, o_beat_addr, o_beat_idx})
    end
    if (o_cmd_valid) begin
      ec = cq.size() ? cq.pop_front() : 'x;
      `CHK("cmd", ec, {o_cmd_kind, o_cmd_grp, o_cmd_addr})
      if (ec[27:26] === `SSDP_CMD_MRS) `CHK("mode", ec[22:0], o_mode_cfg)
    end
    if (o_read_clk_pair_p !== last_rclk && o_read_valid_flag === 1'b1) begin
      er = rq.size() ? rq.pop_front() : 'x;
      `CHK("read", er, o_read_data)
    end
    last_rclk = o_read_clk_pair_p;
    if (o_beat_drop === 1'b1) drops++;
  end
  task automatic issue(input logic we, rf, input logic [22:0] a, input logic [2:0] g);
    u_ctl.cmd(1'b0, we, rf, a, g);
    cq.push_back({we, rf, g, a});
    u_ctl.idle();
  endtask
  task automatic wr(input logic [22:0] a, input logic [2:0] g, input int n, input bit msk, sel);
    logic [17:0] d = 18'h0;
    logic m;
    u_ctl.cmd(!sel, 1'b0, 1'b1, a, g);
    if (sel) cq.push_back({`SSDP_CMD_WRITE, g, a});
    fork
      u_ctl.idle();
      for (int k = 0; k < n; k++) begin
        r = rnd();
        d = r[17:0];
        m = msk && r[31];
        if (sel && !m) bq.push_back({d, g, a, k[2:0]});
        u_ctl.beat(d, m);
      end
    join
    u_ctl.beat(~d, 1'b0);
  endtask
  task automatic rd_send(input logic [17:0] d);
    i_rd_valid = 1'b1;
    i_rd_data = d;
    rq.push_back(d);
    for (int i = 0; i < 4 && o_rd_ready !== 1'b1; i++) @(posedge i_core_clk) #2;
    @(posedge i_core_clk) #2;
  endtask
  task give_verdict();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge i_core_clk);
    #2 i_rst_b = 1'b1;
    for (int b = 0; b < 4; b++) begin
      r = rnd();
      issue(1'b0, 1'b0, {r[22:5], b[1:0], r[2:0]}, r[25:23]);
      r = rnd();
      wr(r[22:0], r[25:23], b == 0 ? 2 : b == 1 ? 4 : 8, 1'b1, 1'b1);
    end
    wr(23'h5, 3'h5, 2, 1'b0, 1'b0);
    issue(1'b1, 1'b0, 23'h7fffff, 3'h7);
    issue(1'b1, 1'b1, 23'h0, 3'h0);
    @(posedge i_core_clk) #2;
    repeat (6) begin r = rnd(); rd_send(r[17:0]); end
    i_rd_valid = 1'b0;
    i_rd_data = ~i_rd_data;
    stall = 1'b1;
    issue(1'b0, 1'b0, 23'h10, 3'h0);
    repeat (3) wr(23'h1, 3'h2, 8, 1'b0, 1'b1);
    `CHK("full", 1'b0, o_wbuf_ready)
    `CHK("drop", 1'b1, drops > 0)
    stall = 1'b0;
    for (int i = 0; i < 600 && bq.size() > drops; i++) @(posedge i_core_clk);
    repeat (20) @(posedge i_core_clk);
    `CHK("left", drops, bq.size())
    `CHK("free", 1'b1, o_wbuf_ready)
    `CHK("pending", 0, cq.size() + rq.size())
    give_verdict();
  end
  // The sequence needs about 9 us; far beyond that means a hang.
  initial begin
    #200000;
    err_total++;
    give_verdict();
  end
endmodule // ssdp_pin_if_bench
